// *** logic/smc_regs.vh ***
`ifndef SMC_REGS_VH
`define SMC_REGS_VH

// sleep mode select encoding
`define SMC_MODE_W        3
`define SMC_MODE_IDLE     3'h0
`define SMC_MODE_ADCNR    3'h1
`define SMC_MODE_PDOWN    3'h2
`define SMC_MODE_PSAVE    3'h3
`define SMC_MODE_STANDBY  3'h6

// clock enable vector bit positions
`define SMC_EN_W          8
`define SMC_EN_CPU        0
`define SMC_EN_MEM        1
`define SMC_EN_TMR        2
`define SMC_EN_SPI        3
`define SMC_EN_IRQ        4
`define SMC_EN_ATMR       5
`define SMC_EN_DISP       6
`define SMC_EN_ADC        7

// enable values
`define SMC_EN_ALL        8'hff
`define SMC_EN_NONE       8'h00

// cycles the oscillator must run after restart before clocks are released
`define SMC_OSC_WAKE_CYC  4'h8
`define SMC_XTAL_WAKE_CYC 4'h1

`endif

// *** logic/smc_mode_decode.v ***
`timescale 1ns/1ps
`default_nettype none
`include "smc_regs.vh"

module smc_mode_decode
(
    input  wire [`SMC_MODE_W-1:0] mode,
    output reg  [`SMC_EN_W-1:0]   clk_en,
    output reg                    osc_on,
    output reg                    valid
);

    always @*
    begin
        clk_en = `SMC_EN_NONE;
        osc_on = 1'b0;
        valid  = 1'b1;
        case (mode)
            `SMC_MODE_IDLE:
            begin
                // cpu halted, rest keeps running
                clk_en = `SMC_EN_ALL;
                clk_en[`SMC_EN_CPU] = 1'b0;
                osc_on = 1'b1;
            end
            `SMC_MODE_ADCNR:
            begin
                clk_en[`SMC_EN_ATMR] = 1'b1;
                clk_en[`SMC_EN_DISP] = 1'b1;
                clk_en[`SMC_EN_ADC]  = 1'b1;
                clk_en[`SMC_EN_IRQ]  = 1'b1;
                osc_on = 1'b1;
            end
            `SMC_MODE_PSAVE:
            begin
                clk_en[`SMC_EN_ATMR] = 1'b1;
                clk_en[`SMC_EN_DISP] = 1'b1;
            end
            `SMC_MODE_PDOWN:
            begin
                osc_on = 1'b0;
            end
            `SMC_MODE_STANDBY:
            begin
                osc_on = 1'b1;
            end
            default:
            begin
                // unused codes do not sleep
                valid  = 1'b0;
                clk_en = `SMC_EN_ALL;
                osc_on = 1'b1;
            end
        endcase
    end

endmodule // smc_mode_decode
`default_nettype wire

// *** logic/smc_sleep_ctrl.v ***
`timescale 1ns/1ps
`default_nettype none
`include "smc_regs.vh"

// Contract
// - five software-selected sleep modes: idle, noise reduction, save, down, standby
// - idle halts cpu clock; memory, timers, serial port, interrupts stay clocked
// - power-down stops main oscillator and all functions, registers retained
// - power-down ends only on interrupt or hardware reset
// - power-save keeps asynchronous timer and display controller clocked
// - noise reduction stops cpu and i/o except async timer, display, converter, interrupts
// - standby keeps crystal oscillator running for fast wake-up
module smc_sleep_ctrl
(
    input  wire                    clk_sys,
    input  wire                    resetn,
    input  wire                    sleep_req,
    input  wire [`SMC_MODE_W-1:0]  sleep_mode,
    input  wire                    wake_irq,
    output reg  [`SMC_EN_W-1:0]    clk_en_ff,
    output reg                     osc_run_ff,
    output reg                     sleeping_ff,
    output reg                     cpu_resume_ff
);

    localparam [3:0] ST_RUN   = 4'b0001;
    localparam [3:0] ST_SLEEP = 4'b0010;
    localparam [3:0] ST_WARM  = 4'b0100;
    localparam [3:0] ST_WAKE  = 4'b1000;

    reg  [3:0]             state_ff;
    reg  [3:0]             nxt_state;
    reg  [3:0]             warm_cnt_ff;
    reg  [3:0]             nxt_warm_cnt;
    reg  [`SMC_EN_W-1:0]   nxt_clk_en;
    reg                    nxt_osc_run;
    reg                    nxt_sleeping;
    reg                    nxt_cpu_resume;
    wire [`SMC_EN_W-1:0]   dec_clk_en;
    wire                   dec_osc_on;
    wire                   dec_valid;
    wire                   take_req;
    wire                   wake_go;
    wire                   warm_end;

    smc_mode_decode u_decode
    (
        .mode   (sleep_mode),
        .clk_en (dec_clk_en),
        .osc_on (dec_osc_on),
        .valid  (dec_valid)
    );

    // a stopped oscillator needs longer to settle than one left running
    function [3:0] warm_load;
        input osc_was_on;
        begin
            if (osc_was_on)
                warm_load = `SMC_XTAL_WAKE_CYC;
            else
                warm_load = `SMC_OSC_WAKE_CYC;
        end
    endfunction

    function warm_last;
        input [3:0] cnt;
        begin
            warm_last = (cnt <= 4'h1);
        end
    endfunction

    // invalid mode codes are ignored so the cpu never hangs
    assign take_req = (state_ff == ST_RUN) && sleep_req && dec_valid && !wake_irq;
    assign wake_go  = (state_ff == ST_SLEEP) && wake_irq;
    assign warm_end = (state_ff == ST_WARM) && warm_last(warm_cnt_ff);

    always @*
    begin
        nxt_state = state_ff;
        case (state_ff)
            ST_RUN:
            begin
                if (take_req)
                    nxt_state = ST_SLEEP;
            end
            ST_SLEEP:
            begin
                // registers keep their contents: only clocks are gated
                if (wake_go)
                    nxt_state = ST_WARM;
            end
            ST_WARM:
            begin
                if (warm_end)
                    nxt_state = ST_WAKE;
            end
            ST_WAKE:
            begin
                nxt_state = ST_RUN;
            end
            default:
            begin
                nxt_state = ST_RUN;
            end
        endcase
    end

    always @*
    begin
        nxt_warm_cnt = warm_cnt_ff;
        case (state_ff)
            ST_SLEEP:
            begin
                if (wake_go)
                    nxt_warm_cnt = warm_load(osc_run_ff);
            end
            ST_WARM:
            begin
                if (!warm_end)
                    nxt_warm_cnt = warm_cnt_ff - 4'h1;
            end
            ST_WAKE:
            begin
                nxt_warm_cnt = 4'h0;
            end
            default:
            begin
                nxt_warm_cnt = warm_cnt_ff;
            end
        endcase
    end

    always @*
    begin
        nxt_clk_en = clk_en_ff;
        case (state_ff)
            ST_RUN:
            begin
                if (take_req)
                    nxt_clk_en = dec_clk_en;
            end
            ST_SLEEP, ST_WARM:
            begin
                // domains stay gated until the oscillator has settled
                nxt_clk_en = clk_en_ff;
            end
            ST_WAKE:
            begin
                nxt_clk_en = `SMC_EN_ALL;
            end
            default:
            begin
                nxt_clk_en = `SMC_EN_ALL;
            end
        endcase
    end

    always @*
    begin
        nxt_osc_run = osc_run_ff;
        case (state_ff)
            ST_RUN:
            begin
                if (take_req)
                    nxt_osc_run = dec_osc_on;
            end
            ST_SLEEP:
            begin
                if (wake_go)
                    nxt_osc_run = 1'b1;
            end
            ST_WARM, ST_WAKE:
            begin
                nxt_osc_run = osc_run_ff;
            end
            default:
            begin
                nxt_osc_run = 1'b1;
            end
        endcase
    end

    always @*
    begin
        nxt_sleeping   = sleeping_ff;
        nxt_cpu_resume = 1'b0;
        case (state_ff)
            ST_RUN:
            begin
                if (take_req)
                    nxt_sleeping = 1'b1;
            end
            ST_SLEEP, ST_WARM:
            begin
                nxt_sleeping = sleeping_ff;
            end
            ST_WAKE:
            begin
                nxt_sleeping   = 1'b0;
                nxt_cpu_resume = 1'b1;
            end
            default:
            begin
                nxt_sleeping = 1'b0;
            end
        endcase
    end

    // hardware reset leaves any sleep mode at once
    always @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            state_ff      <= ST_RUN;
            warm_cnt_ff   <= 4'h0;
            clk_en_ff     <= `SMC_EN_ALL;
            osc_run_ff    <= 1'b1;
            sleeping_ff   <= 1'b0;
            cpu_resume_ff <= 1'b0;
        end
        else
        begin
            state_ff      <= nxt_state;
            warm_cnt_ff   <= nxt_warm_cnt;
            clk_en_ff     <= nxt_clk_en;
            osc_run_ff    <= nxt_osc_run;
            sleeping_ff   <= nxt_sleeping;
            cpu_resume_ff <= nxt_cpu_resume;
        end
    end

endmodule // smc_sleep_ctrl
`default_nettype wire

// *** testbench/smc_chk_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module smc_chk
(
    input wire logic       clk_sys,
    input wire logic       resetn,
    input wire logic       sleep_req,
    input wire logic [2:0] sleep_mode,
    input wire logic       wake_irq,
    input wire logic [7:0] clk_en_ff,
    input wire logic       osc_run_ff,
    input wire logic       sleeping_ff,
    input wire logic       cpu_resume_ff
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    wire       rdy = sleep_req && !sleeping_ff && !cpu_resume_ff;
    wire       go  = rdy && !wake_irq;
    wire [2:0] m   = sleep_mode;
    wire [9:0] st  = {sleeping_ff, osc_run_ff, clk_en_ff};
    AST_IDLE: assert property (go && m == 3'h0 |=> st == 10'h3fe)
        else $error("idle gating wrong");
    AST_ADCNR: assert property (go && m == 3'h1 |=> st == 10'h3f0)
        else $error("noise gating wrong");
    AST_PDOWN: assert property (go && m == 3'h2 |=> st == 10'h200)
        else $error("down gating wrong");
    AST_PSAVE: assert property (go && m == 3'h3 |=> st == 10'h260)
        else $error("save gating wrong");
    AST_STBY: assert property (go && m == 3'h6 |=> st == 10'h300)
        else $error("standby gating wrong");
    AST_REFUSE: assert property (rdy && (wake_irq || m[2] && m != 3'h6) |=> st == 10'h1ff)
        else $error("request not refused");
    AST_HOLD: assert property (sleeping_ff && !osc_run_ff && !wake_irq |=> $stable(st))
        else $error("left sleep early");
    AST_SLOW: assert property (sleeping_ff && !osc_run_ff && wake_irq |=>
        (st[9:8] == 2'h3) [*8] ##2 st == 10'h1ff && cpu_resume_ff) else $error("slow wake");
    AST_FAST: assert property (sleeping_ff && osc_run_ff && $rose(wake_irq) |=>
        sleeping_ff [*2] ##1 st == 10'h1ff && cpu_resume_ff) else $error("fast wake");
endmodule // smc_chk
bind smc_sleep_ctrl smc_chk chk_u (.clk_sys(clk_sys), .resetn(resetn), .sleep_req(sleep_req),
    .sleep_mode(sleep_mode), .wake_irq(wake_irq), .clk_en_ff(clk_en_ff),
    .osc_run_ff(osc_run_ff), .sleeping_ff(sleeping_ff), .cpu_resume_ff(cpu_resume_ff));
`default_nettype wire

// *** testbench/smc_cpu_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module smc_cpu_model
(
    input  wire logic       clk_sys,
    input  wire logic       go,
    input  wire logic       irq,
    input  wire logic [2:0] mode,
    output var  logic       sleep_req,
    output var  logic [2:0] sleep_mode,
    output var  logic       wake_irq
);
    // core and interrupt source both launch on the falling edge
    always @(negedge clk_sys)
    begin
        sleep_req  <= go;
        sleep_mode <= mode;
        wake_irq   <= irq;
    end
endmodule // smc_cpu_model
`default_nettype wire

// *** testbench/test_sleep_mode_clock_gating.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "smc_regs.vh"
module test_sleep_mode_clock_gating;
    logic       clk_sys = 1'b0, resetn = 1'b0, go = 1'b0, irq = 1'b0;
    logic [2:0] mode = 3'h0;
    wire        sleep_req, wake_irq, osc_run_ff, sleeping_ff, cpu_resume_ff;
    wire  [2:0] sleep_mode;
    wire  [7:0] clk_en_ff;
    wire  [9:0] st = {sleeping_ff, osc_run_ff, clk_en_ff};
    int         error_cnt = 0, n_checks = 0;
    always #5 clk_sys = ~clk_sys;
    smc_cpu_model cpu_u (.clk_sys(clk_sys), .go(go), .irq(irq), .mode(mode),
        .sleep_req(sleep_req), .sleep_mode(sleep_mode), .wake_irq(wake_irq));
    smc_sleep_ctrl dut_u (.clk_sys(clk_sys), .resetn(resetn), .sleep_req(sleep_req),
        .sleep_mode(sleep_mode), .wake_irq(wake_irq), .clk_en_ff(clk_en_ff),
        .osc_run_ff(osc_run_ff), .sleeping_ff(sleeping_ff), .cpu_resume_ff(cpu_resume_ff));
    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic step(input logic g, input logic i, input logic [2:0] m);
        @(posedge clk_sys);
        #1;
        go = g;
        irq = i;
        mode = m;
    endtask
    task automatic refuse(input logic i, input logic [2:0] m);
        step(1'b1, i, m);
        step(1'b0, 1'b0, m);
        @(negedge clk_sys);
        chk(st, 10'h1ff);
        $display("refusal of mode %0d done", m);
    endtask
    task automatic reset_asleep;
        step(1'b1, 1'b0, `SMC_MODE_PDOWN);
        step(1'b0, 1'b0, `SMC_MODE_PDOWN);
        @(negedge clk_sys);
        chk(st, 10'h200);
        step(1'b1, 1'b0, `SMC_MODE_IDLE);
        step(1'b0, 1'b0, `SMC_MODE_IDLE);
        @(negedge clk_sys);
        chk(st, 10'h200);
        resetn = 1'b0;
        #1;
        chk(st, 10'h1ff);
        repeat (2) @(negedge clk_sys);
        resetn = 1'b1;
        repeat (3) @(negedge clk_sys);
        chk(st, 10'h1ff);
        $display("reset wake done");
    endtask
    task automatic do_mode(input logic [2:0] m, input logic [9:0] exp, input int lat);
        int n;
        step(1'b1, 1'b0, m);
        step(1'b0, 1'b0, m);
        repeat (3) @(negedge clk_sys);
        chk(st, exp);
        step(1'b0, 1'b1, m);
        n = 0;
        do
        begin
            @(negedge clk_sys);
            n++;
        end while (cpu_resume_ff !== 1'b1 && n < 20);
        if (cpu_resume_ff !== 1'b1)
        begin
            error_cnt++;
            $display("wrong value at %0t: got %h exp %h", $time, 1'b0, 1'b1);
            complete_run();
        end
        else
        begin
            chk(10'(n - 1), 10'(lat));
            chk(st, 10'h1ff);
            step(1'b0, 1'b0, m);
            @(negedge clk_sys);
            chk({9'h000, cpu_resume_ff}, 10'h000);
            $display("mode %0d done", m);
        end
    endtask
    initial
    begin
        repeat (12) @(negedge clk_sys);
        resetn = 1'b1;
        chk(st, 10'h1ff);
        refuse(1'b0, 3'h5);
        refuse(1'b0, 3'h7);
        refuse(1'b1, `SMC_MODE_PDOWN);
        // each wake is followed closely by the next request
        do_mode(`SMC_MODE_IDLE, 10'h3fe, 3);
        do_mode(`SMC_MODE_ADCNR, 10'h3f0, 3);
        do_mode(`SMC_MODE_PDOWN, 10'h200, 10);
        do_mode(`SMC_MODE_PSAVE, 10'h260, 10);
        do_mode(`SMC_MODE_STANDBY, 10'h300, 3);
        reset_asleep();
        do_mode(`SMC_MODE_STANDBY, 10'h300, 3);
        complete_run();
    end
endmodule // test_sleep_mode_clock_gating
`default_nettype wire
